// *** sso_regs.vh ***
// Register map, field positions, reset values and timing counts for the servo status outputs
`ifndef SSO_REGS_VH
`define SSO_REGS_VH

// ==========================================================================
// Register offsets (byte addresses)
`define SSO_CTRL_OFS        8'h00
`define SSO_ASSIGN_OFS      8'h04
`define SSO_LOCK_DLY_OFS    8'h08
`define SSO_INPOS_OFS       8'h0C
`define SSO_ZSP_OFS         8'h10
`define SSO_SETSPD_OFS      8'h14
`define SSO_SPDLIM_OFS      8'h18
`define SSO_DROOP_OFS       8'h1C
`define SSO_SPEED_OFS       8'h20
`define SSO_FLAGS_OFS       8'h24
`define SSO_IRQ_STAT_OFS    8'h28
`define SSO_IRQ_MASK_OFS    8'h2C

// ==========================================================================
// Control register fields
`define SSO_CTRL_SERVO_ON   0
`define SSO_CTRL_ALARM      1
`define SSO_CTRL_BASE_OFF   2
`define SSO_CTRL_DRV_RDY    3
`define SSO_CTRL_MODE_LO    4
`define SSO_CTRL_MODE_HI    5
`define SSO_CTRL_TQ_CONT    6

// Control modes
`define SSO_MODE_POS        2'h0
`define SSO_MODE_SPD        2'h1
`define SSO_MODE_TRQ        2'h2

// ==========================================================================
// Flag codes, also bit positions in the flags and interrupt registers
`define SSO_FLAG_NONE       3'h0
`define SSO_FLAG_BRAKE      3'h1
`define SSO_FLAG_MALF       3'h2
`define SSO_FLAG_INPOS      3'h3
`define SSO_FLAG_READY      3'h4
`define SSO_FLAG_SPDRCH     3'h5
`define SSO_FLAG_SPDLIM     3'h6
`define SSO_FLAG_ZSPD       3'h7

// Pin assignment defaults: {pin_c, pin_b, pin_a}
`define SSO_ASSIGN_RST      9'h0D1

// ==========================================================================
// Reset values of settings and fixed speed thresholds
`define SSO_LOCK_DLY_RST    16'h0064
`define SSO_INPOS_RST       16'h0064
`define SSO_ZSP_RST         16'h0032
`define SSO_ZSP_HYST        16'h0014
`define SSO_SPD_TOL_ABS     16'h0014
`define SSO_SPD_LOW_LIM     16'h0014

// ==========================================================================
// Timing: clock rate and power-on delay window
`define SSO_CLK_HZ          50000000
`define SSO_MALF_MIN_MS     2500
`define SSO_MALF_MAX_MS     3500
`define SSO_MALF_DLY_MS     3000
`define SSO_MS_CYCLES       (`SSO_CLK_HZ / 1000)

`endif

// *** sso_status_outputs.v ***
// Servo status output flags with pin assignment, register slave and interrupt
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "sso_regs.vh"

module sso_status_outputs
#(
   parameter MALF_DLY_MS = `SSO_MALF_DLY_MS,
   parameter MS_CYCLES   = `SSO_MS_CYCLES
)
(
   input  wire        clk_i,            // System clock, 50 MHz
   input  wire        rst_i,            // Synchronous reset, high
   input  wire [7:0]  adr_i,            // Wishbone byte address
   input  wire [31:0] dat_i,            // Wishbone write data
   output reg  [31:0] dat_o,            // Wishbone read data
   input  wire        we_i,             // Wishbone write enable
   input  wire [3:0]  sel_i,            // Wishbone byte selects
   input  wire        cyc_i,            // Wishbone cycle
   input  wire        stb_i,            // Wishbone strobe
   output reg         ack_o,            // Wishbone acknowledge
   output reg         pin_a_o,          // Output pin A
   output reg         pin_b_o,          // Output pin B
   output reg         pin_c_o,          // Output pin C
   output reg         irq_o             // Level interrupt
);

   // ==========================================================================
   // Register storage
   reg  [6:0]  ctrl_q;
   reg  [8:0]  assign_q;
   reg  [15:0] lock_dly_q;
   reg  [15:0] inpos_q;
   reg  [15:0] zsp_q;
   reg  [15:0] setspd_q;
   reg  [15:0] spdlim_q;
   reg  [15:0] droop_q;
   reg  [15:0] speed_q;
   reg  [7:0]  irq_stat_q;
   reg  [7:0]  irq_mask_q;
   reg  [7:0]  flags_q;
   reg  [7:0]  flags_prev_q;

   wire        bus_req  = cyc_i & stb_i & ~ack_o;
   wire        bus_wr   = bus_req & we_i;
   wire        bus_rd   = bus_req & ~we_i;

   wire        servo_on = ctrl_q[`SSO_CTRL_SERVO_ON];
   wire        alarm    = ctrl_q[`SSO_CTRL_ALARM];
   wire        base_off = ctrl_q[`SSO_CTRL_BASE_OFF];
   wire        drv_rdy  = ctrl_q[`SSO_CTRL_DRV_RDY];
   wire [1:0]  mode     = ctrl_q[`SSO_CTRL_MODE_HI:`SSO_CTRL_MODE_LO];
   wire        tq_cont  = ctrl_q[`SSO_CTRL_TQ_CONT];

   // Merge a 16-bit setting with the byte selects
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] wd;
      input [3:0]  sel;
      begin
         merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
      end
   endfunction

   // ==========================================================================
   // Millisecond tick and timers
   reg  [15:0] ms_div_q;
   reg         ms_tick_q;
   reg  [11:0] malf_cnt_q;
   reg         malf_done_q;
   reg  [15:0] lock_cnt_q;
   reg         brake_q;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ms_div_q  <= 16'h0000;
         ms_tick_q <= 1'b0;
      end
      else if (ms_div_q == MS_CYCLES - 1)
      begin
         ms_div_q  <= 16'h0000;
         ms_tick_q <= 1'b1;
      end
      else
      begin
         ms_div_q  <= ms_div_q + 16'h0001;
         ms_tick_q <= 1'b0;
      end
   end

   // Power-on delay restarts on reset; midpoint keeps margin both ways
   // power-on delay
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         malf_cnt_q  <= 12'h000;
         malf_done_q <= 1'b0;
      end
      else if (ms_tick_q && !malf_done_q)
      begin
         if (malf_cnt_q == MALF_DLY_MS - 1)
            malf_done_q <= 1'b1;
         malf_cnt_q <= malf_cnt_q + 12'h001;
      end
   end

   // Brake released after delay, dropped at once on off or alarm
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lock_cnt_q <= 16'h0000;
         brake_q    <= 1'b0;
      end
      else if (!servo_on || alarm)
      begin
         lock_cnt_q <= 16'h0000;
         brake_q    <= 1'b0;
      end
      else if (!brake_q)
      begin
         if (lock_cnt_q >= lock_dly_q)
            brake_q <= 1'b1;
         else if (ms_tick_q)
            lock_cnt_q <= lock_cnt_q + 16'h0001;
      end
   end

   // ==========================================================================
   // Flag derivation
   wire [15:0] spd_abs  = speed_q[15] ? (~speed_q + 16'h0001) : speed_q;
   wire [15:0] set_abs  = setspd_q[15] ? (~setspd_q + 16'h0001) : setspd_q;
   wire [15:0] drp_abs  = droop_q[15] ? (~droop_q + 16'h0001) : droop_q;
   // Tolerance = set/20 + 20, widened to avoid overflow
   wire [17:0] tol      = {2'b00, set_abs} / 18'd20 + {2'b00, `SSO_SPD_TOL_ABS};
   wire [17:0] spd_w    = {2'b00, spd_abs};
   wire [17:0] set_w    = {2'b00, set_abs};
   wire        sign_ok  = (speed_q[15] == setspd_q[15]) || (spd_abs == 16'h0000);
   wire [17:0] zsp_off  = {2'b00, zsp_q} + {2'b00, `SSO_ZSP_HYST};

   reg         zspd_q;
   reg  [7:0]  flags_d;

   always @(posedge clk_i)
   begin
      if (rst_i)
         zspd_q <= 1'b1;
      else if (spd_abs <= zsp_q)
         zspd_q <= 1'b1;
      else if (spd_w >= zsp_off)
         zspd_q <= 1'b0;
   end

   always @*
   begin
      flags_d = 8'h00;
      flags_d[`SSO_FLAG_BRAKE] = brake_q;
      flags_d[`SSO_FLAG_MALF]  = malf_done_q & ~base_off & ~alarm;
      flags_d[`SSO_FLAG_INPOS] = (mode == `SSO_MODE_POS) & ~tq_cont & (drp_abs <= inpos_q);
      flags_d[`SSO_FLAG_READY] = servo_on & drv_rdy & ~alarm;
      flags_d[`SSO_FLAG_SPDRCH] = servo_on & (mode == `SSO_MODE_SPD) &
                                  ((set_abs <= `SSO_SPD_LOW_LIM) ||
                                   (sign_ok && spd_w + tol >= set_w && spd_w <= set_w + tol));
      flags_d[`SSO_FLAG_SPDLIM] = servo_on & (mode == `SSO_MODE_TRQ) & (spd_abs >= spdlim_q);
      flags_d[`SSO_FLAG_ZSPD]   = zspd_q;
   end

   // ==========================================================================
   // Flags, pins and interrupt
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flags_q      <= 8'h00;
         flags_prev_q <= 8'h00;
         pin_a_o      <= 1'b0;
         pin_b_o      <= 1'b0;
         pin_c_o      <= 1'b0;
         irq_o        <= 1'b0;
      end
      else
      begin
         flags_q      <= flags_d;
         flags_prev_q <= flags_q;
         pin_a_o      <= flags_q[assign_q[2:0]];
         pin_b_o      <= flags_q[assign_q[5:3]];
         pin_c_o      <= flags_q[assign_q[8:6]];
         irq_o        <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Any flag change is an event; set wins over read-clear
   wire [7:0]  flag_evt = (flags_q ^ flags_prev_q) & 8'hFE;
   wire        stat_rd  = bus_rd && adr_i == `SSO_IRQ_STAT_OFS;

   always @(posedge clk_i)
   begin
      if (rst_i)
         irq_stat_q <= 8'h00;
      else if (stat_rd)
         irq_stat_q <= flag_evt;
      else
         irq_stat_q <= irq_stat_q | flag_evt;
   end

   // ==========================================================================
   // Wishbone slave, one wait state, unmapped reads zero
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o      <= 1'b0;
         dat_o      <= 32'h00000000;
         ctrl_q     <= 7'h00;
         assign_q   <= `SSO_ASSIGN_RST;
         lock_dly_q <= `SSO_LOCK_DLY_RST;
         inpos_q    <= `SSO_INPOS_RST;
         zsp_q      <= `SSO_ZSP_RST;
         setspd_q   <= 16'h0000;
         spdlim_q   <= 16'h0000;
         droop_q    <= 16'h0000;
         speed_q    <= 16'h0000;
         irq_mask_q <= 8'h00;
      end
      else
      begin
         ack_o <= bus_req;
         dat_o <= 32'h00000000;
         if (bus_wr)
         begin
            case (adr_i)
               `SSO_CTRL_OFS:     if (sel_i[0]) ctrl_q <= dat_i[6:0];
               `SSO_ASSIGN_OFS:   assign_q <= {sel_i[1] ? dat_i[8] : assign_q[8], sel_i[0] ? dat_i[7:0] : assign_q[7:0]};
               `SSO_LOCK_DLY_OFS: lock_dly_q <= merge16(lock_dly_q, dat_i, sel_i);
               `SSO_INPOS_OFS:    inpos_q <= merge16(inpos_q, dat_i, sel_i);
               `SSO_ZSP_OFS:      zsp_q <= merge16(zsp_q, dat_i, sel_i);
               `SSO_SETSPD_OFS:   setspd_q <= merge16(setspd_q, dat_i, sel_i);
               `SSO_SPDLIM_OFS:   spdlim_q <= merge16(spdlim_q, dat_i, sel_i);
               `SSO_DROOP_OFS:    droop_q <= merge16(droop_q, dat_i, sel_i);
               `SSO_SPEED_OFS:    speed_q <= merge16(speed_q, dat_i, sel_i);
               `SSO_IRQ_MASK_OFS: if (sel_i[0]) irq_mask_q <= dat_i[7:0];
               default:           ;
            endcase
         end
         if (bus_rd)
         begin
            case (adr_i)
               `SSO_CTRL_OFS:     dat_o <= {25'h0000000, ctrl_q};
               `SSO_ASSIGN_OFS:   dat_o <= {23'h000000, assign_q};
               `SSO_LOCK_DLY_OFS: dat_o <= {16'h0000, lock_dly_q};
               `SSO_INPOS_OFS:    dat_o <= {16'h0000, inpos_q};
               `SSO_ZSP_OFS:      dat_o <= {16'h0000, zsp_q};
               `SSO_SETSPD_OFS:   dat_o <= {16'h0000, setspd_q};
               `SSO_SPDLIM_OFS:   dat_o <= {16'h0000, spdlim_q};
               `SSO_DROOP_OFS:    dat_o <= {16'h0000, droop_q};
               `SSO_SPEED_OFS:    dat_o <= {16'h0000, speed_q};
               `SSO_FLAGS_OFS:    dat_o <= {24'h000000, flags_q};
               `SSO_IRQ_STAT_OFS: dat_o <= {24'h000000, irq_stat_q};
               `SSO_IRQ_MASK_OFS: dat_o <= {24'h000000, irq_mask_q};
               default:           dat_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

// *** sso_status_properties.sv ***
// Bus handshake and pin timing properties of the servo status outputs
`timescale 1ns/100ps
module sso_status_properties
(
   input wire logic        clk_i,   // Clock
   input wire logic        rst_i,   // Reset
   input wire logic [7:0]  adr_i,   // Address
   input wire logic [31:0] dat_i,   // Write data
   input wire logic [31:0] dat_o,   // Read data
   input wire logic        we_i,    // Write enable
   input wire logic [3:0]  sel_i,   // Byte selects
   input wire logic        cyc_i,   // Cycle
   input wire logic        stb_i,   // Strobe
   input wire logic        ack_o,   // Acknowledge
   input wire logic        pin_a_o, // Pin A
   input wire logic        pin_b_o, // Pin B
   input wire logic        pin_c_o, // Pin C
   input wire logic        irq_o    // Interrupt
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ====
   // Bus handshake
   a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_idle_data: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   a_unmapped_zero: assert property (ack_o && $past(!we_i && (adr_i > 8'h2C || adr_i[1:0] != 2'h0)) |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   // ====
   // Flags and pins
   a_none_flag: assert property (ack_o && $past(!we_i && (adr_i == 8'h24 || adr_i == 8'h28)) |-> !dat_o[0])
      else $error("unused flag bit set");
   a_pins_quiet: assert property ($fell(rst_i) |-> (!pin_a_o && !pin_b_o && !pin_c_o && !irq_o) [*2])
      else $error("outputs active right after reset");
   // Only a status read or mask write may lower the interrupt
   a_irq_fall: assert property ($fell(irq_o) |-> (ack_o || $past(ack_o)) && $past(adr_i == 8'h28 || adr_i == 8'h2C))
      else $error("interrupt dropped without clear");
   c_write: cover property (ack_o && $past(we_i));
   c_stat_read: cover property (ack_o && $past(!we_i && adr_i == 8'h28));
   c_irq: cover property ($rose(irq_o));
endmodule

// *** sso_plc_model.sv ***
// Controller side model that scans the three status pins
`timescale 1ns/100ps
module sso_plc_model
(
   input  wire logic       clk_i,  // Clock
   input  wire logic [2:0] pins_i, // Pins {c,b,a}
   output logic      [2:0] seen_o  // Scanned pins
);
   // One scan of delay, as a real input stage
   always @(posedge clk_i)
   begin
      seen_o <= pins_i;
   end
endmodule

// *** sso_tb.sv ***
// Self-checking bench for the servo status outputs
`timescale 1ns/100ps
module tb;
   logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, irq_o;
   logic        pin_a_o, pin_b_o, pin_c_o;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [2:0]  seen;
   int          error_cnt, total_checks;
   typedef struct {logic [7:0] c; logic [15:0] s, l, d, v; logic [2:0] f; logic e;} sso_row_t;
   // Row: ctrl, set speed, limit, droop, speed, flag code, expected pin A
   sso_row_t rows [27] = '{
      '{8'h09,16'h0,16'h0,16'h0,16'h0,3'h4,1'b1}, '{8'h0B,16'h0,16'h0,16'h0,16'h0,3'h4,1'b0},
      '{8'h01,16'h0,16'h0,16'h0,16'h0,3'h4,1'b0}, '{8'h09,16'h0,16'h0,16'h64,16'h0,3'h3,1'b1},
      '{8'h09,16'h0,16'h0,16'h65,16'h0,3'h3,1'b0}, '{8'h09,16'h0,16'h0,16'hFF9C,16'h0,3'h3,1'b1},
      '{8'h19,16'h0,16'h0,16'h0,16'h0,3'h3,1'b0}, '{8'h49,16'h0,16'h0,16'h0,16'h0,3'h3,1'b0},
      '{8'h19,16'h3E8,16'h0,16'h0,16'h42E,3'h5,1'b1}, '{8'h19,16'h3E8,16'h0,16'h0,16'h42F,3'h5,1'b0},
      '{8'h19,16'h3E8,16'h0,16'h0,16'h3A2,3'h5,1'b1}, '{8'h19,16'h3E8,16'h0,16'h0,16'h3A1,3'h5,1'b0},
      '{8'h18,16'h3E8,16'h0,16'h0,16'h3E8,3'h5,1'b0}, '{8'h19,16'h14,16'h0,16'h0,16'h1F4,3'h5,1'b1},
      '{8'h09,16'h3E8,16'h0,16'h0,16'h3E8,3'h5,1'b0}, '{8'h29,16'h3E8,16'h0,16'h0,16'h3E8,3'h5,1'b0},
      '{8'h29,16'h0,16'h1F4,16'h0,16'h1F4,3'h6,1'b1}, '{8'h29,16'h0,16'h1F4,16'h0,16'h1F3,3'h6,1'b0},
      '{8'h29,16'h0,16'h1F4,16'h0,16'hFE0C,3'h6,1'b1}, '{8'h28,16'h0,16'h1F4,16'h0,16'h1F4,3'h6,1'b0},
      '{8'h19,16'h0,16'h1F4,16'h0,16'h1F4,3'h6,1'b0}, '{8'h09,16'h0,16'h0,16'h0,16'h64,3'h7,1'b0},
      '{8'h09,16'h0,16'h0,16'h0,16'h32,3'h7,1'b1}, '{8'h09,16'h0,16'h0,16'h0,16'h45,3'h7,1'b1},
      '{8'h09,16'h0,16'h0,16'h0,16'h46,3'h7,1'b0}, '{8'h09,16'h0,16'h0,16'h0,16'hFFCE,3'h7,1'b1},
      '{8'h09,16'h0,16'h0,16'h0,16'hFFBA,3'h7,1'b0}};
   logic [7:0]  ra [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h30};
   logic [31:0] rv [5] = '{32'h0D1, 32'h64, 32'h64, 32'h32, 32'h0};

   sso_status_outputs #(.MALF_DLY_MS(5), .MS_CYCLES(10)) DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
      .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .pin_a_o(pin_a_o), .pin_b_o(pin_b_o), .pin_c_o(pin_c_o), .irq_o(irq_o));
   sso_plc_model plc (.clk_i(clk_i), .pins_i({pin_c_o, pin_b_o, pin_a_o}), .seen_o(seen));

   task summarize;
   begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // Classic single cycle, held until ack is sampled
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
   begin
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      summarize();
   end
   initial
   begin
      {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {4'h8, 8'h0, 32'h0, 4'h0};
      error_cnt = 0;
      total_checks = 0;
      wt(6);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b0, ra[i], 32'h0);
         chk(rd, rv[i]);
      end
      chk(seen[1], 1'b0);
      wt(60);
      chk(seen[1], 1'b1);
      wb(1'b1, 8'h00, 32'h04);
      wt(6);
      chk(seen[1], 1'b0);
      foreach (rows[i])
      begin
         wb(1'b1, 8'h00, {24'h0, rows[i].c});
         wb(1'b1, 8'h14, {16'h0, rows[i].s});
         wb(1'b1, 8'h18, {16'h0, rows[i].l});
         wb(1'b1, 8'h1C, {16'h0, rows[i].d});
         wb(1'b1, 8'h20, {16'h0, rows[i].v});
         wb(1'b1, 8'h04, {23'h0, 9'h0D0 | rows[i].f});
         wt(6);
         chk(seen[0], rows[i].e);
      end
      // Brake follows lock delay of 3 ms, drops fast on alarm
      wb(1'b1, 8'h04, 32'h0D1);
      wb(1'b1, 8'h08, 32'h03);
      wb(1'b1, 8'h00, 32'h08);
      wt(10);
      wb(1'b1, 8'h00, 32'h09);
      wt(15);
      chk(seen[0], 1'b0);
      wt(40);
      chk(seen[0], 1'b1);
      wb(1'b1, 8'h00, 32'h0B);
      wt(6);
      chk(seen[0], 1'b0);
      // Interrupt on ready change, masked and unmasked
      wb(1'b1, 8'h2C, 32'h10);
      wb(1'b0, 8'h28, 32'h0);
      // Ready must really change here: the previous control word had alarm set, so ready was already low
      wb(1'b1, 8'h00, 32'h09);
      wt(4);
      chk(irq_o, 1'b1);
      wb(1'b0, 8'h28, 32'h0);
      chk(rd[4], 1'b1);
      wt(3);
      chk(irq_o, 1'b0);
      wb(1'b1, 8'h2C, 32'h0);
      wb(1'b1, 8'h00, 32'h01);
      wt(4);
      chk(irq_o, 1'b0);
      wb(1'b1, 8'h00, 32'h09);
      // Ready routed to pins B and C, none on A
      wb(1'b1, 8'h04, 32'h120);
      wt(6);
      chk(seen, 3'b110);
      summarize();
   end
endmodule

bind sso_status_outputs sso_status_properties u_chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
   .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .pin_a_o(pin_a_o),
   .pin_b_o(pin_b_o), .pin_c_o(pin_c_o), .irq_o(irq_o));
